// *** core/hbcf_sync.sv ***
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps
module hbcf_sync
	import hbcf_pkg::*;
#(
	parameter int W = 12
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// a bit moves only once stages two and three agree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (s2_q[i] == s3_q[i])
					q[i] <= s3_q[i];
			end
		end
	end
endmodule : hbcf_sync

// *** core/hbcf_timer.sv ***
// Loadable down counter for blanking and off intervals.
`timescale 1ns/1ps
module hbcf_timer
	import hbcf_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic load,
	input wire logic [TMR_W-1:0] load_val,
	output logic done
);
	logic [TMR_W-1:0] cnt_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= '0;
			done <= 1'b0;
		end else if (load) begin
			cnt_q <= load_val;
			done <= 1'b0;
		end else begin
			done <= (cnt_q == TMR_W'(1));
			if (cnt_q != '0)
				cnt_q <= cnt_q - TMR_W'(1);
		end
	end
endmodule : hbcf_timer

// *** core/hbcf_top.sv ***
// H-bridge control, protection and current-limit logic with an AXI4-Lite register slave.
//
// Design decisions made here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module hbcf_top
	import hbcf_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire hbcf_pins_t pins,
	input wire hbcf_pins_t pins_open,
	input wire logic uv_detect,
	input wire logic [7:0] i_load,
	input wire logic [7:0] tj,
	input wire logic fault_status_n_rd,
	output logic fault_status_n_drv,
	output logic fault_status_n_oe,
	output logic bridge_out_a,
	output logic bridge_out_a_oe,
	output logic bridge_out_b,
	output logic bridge_out_b_oe,
	output logic irq
);
	localparam int SYNC_W = 12;

	logic [SYNC_W-1:0] sync_q;
	hbcf_pins_t pin_s, open_s;
	logic uv_s, fs_pin_s, en_eff, dis_hi_eff, dis_lo_n_eff, pol_a_eff, pol_b_eff, dis_active;
	logic dis_hi_prev_q, dis_lo_prev_q, clear_edge, over, ot_now, cool;
	logic [7:0] i_q, tj_q, thr_q, ilim_nom_q, hyst_q;
	logic oc_lat_q, ot_lat_q, ot_hold_q, uv_prev_q, drive_ok, driving;
	hbcf_cl_state_t cl_q, cl_d;
	logic tmr_load, tmr_done, oc_set, ilim_ev;
	logic [TMR_W-1:0] tmr_val;
	logic [NUM_EV-1:0] irq_status_q, irq_mask_q, ev, w1c;
	logic aw_got_q, w_got_q, do_wr;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q, rd_word;
	logic [3:0] wstrb_q;
	hbcf_sel_t wsel, rsel;

	hbcf_sync #(
		.W(SYNC_W)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d({pins, pins_open, uv_detect, fault_status_n_rd}),
		.q(sync_q)
	);

	assign pin_s = sync_q[11:7];
	assign open_s = sync_q[6:2];
	assign uv_s = sync_q[1];
	assign fs_pin_s = sync_q[0];

	// open pins fall to their internal pull levels
	assign en_eff = pin_s.sleep_enable & ~open_s.sleep_enable;
	assign dis_hi_eff = pin_s.disable_high_active | open_s.disable_high_active;
	assign dis_lo_n_eff = pin_s.disable_low_active_n & ~open_s.disable_low_active_n;
	assign pol_a_eff = pin_s.polarity_a_in | open_s.polarity_a_in;
	assign pol_b_eff = pin_s.polarity_b_in | open_s.polarity_b_in;
	assign dis_active = dis_hi_eff | ~dis_lo_n_eff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dis_hi_prev_q <= 1'b0;
			dis_lo_prev_q <= 1'b1;
		end else begin
			dis_hi_prev_q <= dis_hi_eff;
			dis_lo_prev_q <= dis_lo_n_eff;
		end
	end

	assign clear_edge = (dis_hi_prev_q & ~dis_hi_eff) | (~dis_lo_prev_q & dis_lo_n_eff);

	// converter codes already live on aclk, one register stage only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			i_q <= 8'h00;
			tj_q <= 8'h00;
			thr_q <= ILIM_NOM_RST;
		end else begin
			i_q <= i_load;
			tj_q <= tj;
			thr_q <= fold_thr(ilim_nom_q, tj_q);
		end
	end

	assign over = (i_q >= thr_q);
	assign ot_now = (tj_q > TJ_LIM_C);
	assign cool = (tj_q < (TJ_LIM_C - hyst_q));

	// a new fault in the clearing cycle wins; power cycle is the reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			oc_lat_q <= 1'b0;
		end else if (oc_set) begin
			oc_lat_q <= 1'b1;
		end else if (clear_edge) begin
			oc_lat_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ot_lat_q <= 1'b0;
		end else if (ot_now) begin
			ot_lat_q <= 1'b1;
		end else if (clear_edge) begin
			ot_lat_q <= 1'b0;
		end
	end

	// after a thermal clear the flag goes, the stage waits for cooling
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ot_hold_q <= 1'b0;
		end else if (ot_now) begin
			ot_hold_q <= 1'b1;
		end else if (cool) begin
			ot_hold_q <= 1'b0;
		end
	end

	// sleep first, then faults, then disables
	assign drive_ok = en_eff & ~oc_lat_q & ~ot_lat_q & ~ot_hold_q & ~uv_s
		& ~dis_active;

	always_comb begin
		cl_d = cl_q;
		tmr_load = 1'b0;
		tmr_val = BLANK_CYC;
		oc_set = 1'b0;
		ilim_ev = 1'b0;
		unique case (cl_q)
			CL_IDLE: begin
				if (drive_ok) begin
					cl_d = CL_BLANK;
					tmr_load = 1'b1;
				end
			end
			CL_BLANK: begin
				if (!drive_ok) begin
					cl_d = CL_IDLE;
				end else if (tmr_done) begin
					if (over) begin
						oc_set = 1'b1;
						cl_d = CL_IDLE;
					end else begin
						cl_d = CL_RUN;
					end
				end
			end
			CL_RUN: begin
				if (!drive_ok) begin
					cl_d = CL_IDLE;
				end else if (over) begin
					cl_d = CL_OFF;
					tmr_load = 1'b1;
					tmr_val = OFF_CYC;
					ilim_ev = 1'b1;
				end
			end
			CL_OFF: begin
				if (!drive_ok) begin
					cl_d = CL_IDLE;
				end else if (tmr_done) begin
					cl_d = CL_BLANK;
					tmr_load = 1'b1;
				end
			end
			default: begin
				cl_d = CL_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			cl_q <= CL_IDLE;
		else
			cl_q <= cl_d;
	end

	hbcf_timer u_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.load(tmr_load),
		.load_val(tmr_val),
		.done(tmr_done)
	);

	assign driving = drive_ok & ((cl_q == CL_BLANK) | (cl_q == CL_RUN));

	// undriven outputs park low so the wire is decided by the enable alone
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bridge_out_a <= 1'b0;
			bridge_out_a_oe <= 1'b0;
			bridge_out_b <= 1'b0;
			bridge_out_b_oe <= 1'b0;
		end else begin
			bridge_out_a <= driving & pol_a_eff;
			bridge_out_a_oe <= driving;
			bridge_out_b <= driving & pol_b_eff;
			bridge_out_b_oe <= driving;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fault_status_n_drv <= 1'b0;
			fault_status_n_oe <= 1'b0;
		end else begin
			fault_status_n_drv <= 1'b0;
			fault_status_n_oe <= en_eff & (dis_active | uv_s | oc_lat_q | ot_lat_q);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			uv_prev_q <= 1'b0;
		else
			uv_prev_q <= uv_s;
	end

	always_comb begin
		ev = '0;
		ev[EV_UV] = uv_s & ~uv_prev_q;
		ev[EV_UV_REC] = ~uv_s & uv_prev_q;
		ev[EV_OC] = oc_set;
		ev[EV_OT] = ot_now & ~ot_lat_q;
		ev[EV_ILIM] = ilim_ev;
	end

	// axi4-lite register slave, one access per channel at a time
	assign wsel = reg_sel(awaddr_q);
	assign rsel = reg_sel(s_axi_araddr);
	assign do_wr = aw_got_q & w_got_q & ~s_axi_bvalid;
	assign w1c = (do_wr && wsel == SEL_IRQ_STATUS && wstrb_q[0]) ? wdata_q[NUM_EV-1:0] : '0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q <= 1'b0;
			awaddr_q <= '0;
			s_axi_awready <= 1'b1;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_got_q <= 1'b1;
			awaddr_q <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end else if (do_wr) begin
			aw_got_q <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_got_q <= 1'b0;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			s_axi_wready <= 1'b1;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_got_q <= 1'b1;
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end else if (do_wr) begin
			w_got_q <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_wready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (do_wr) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// only byte lane zero carries the narrow fields
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ilim_nom_q <= ILIM_NOM_RST;
			hyst_q <= HYST_RST;
			irq_mask_q <= IRQ_RST;
		end else if (do_wr && wstrb_q[0]) begin
			if (wsel == SEL_ILIM)
				ilim_nom_q <= wdata_q[7:0];
			if (wsel == SEL_HYST)
				hyst_q <= wdata_q[7:0];
			if (wsel == SEL_IRQ_MASK)
				irq_mask_q <= wdata_q[NUM_EV-1:0];
		end
	end

	// set beats a simultaneous write-one-to-clear
	always_ff @(posedge aclk) begin
		if (!aresetn)
			irq_status_q <= IRQ_RST;
		else
			irq_status_q <= (irq_status_q & ~w1c) | ev;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			irq <= 1'b0;
		else
			irq <= |(((irq_status_q & ~w1c) | ev) & irq_mask_q);
	end

	always_comb begin
		rd_word = 32'h00000000;
		unique case (rsel)
			SEL_ILIM: rd_word[7:0] = ilim_nom_q;
			SEL_HYST: rd_word[7:0] = hyst_q;
			SEL_IRQ_STATUS: rd_word[NUM_EV-1:0] = irq_status_q;
			SEL_IRQ_MASK: rd_word[NUM_EV-1:0] = irq_mask_q;
			SEL_STATE: rd_word[11:0] = {dis_active, en_eff, fs_pin_s, driving, uv_s,
				ot_hold_q, ot_lat_q, oc_lat_q, cl_q};
			SEL_LIMIT: rd_word[7:0] = thr_q;
			SEL_NONE: rd_word = 32'h00000000;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule : hbcf_top

// *** pkg/hbcf_pkg.sv ***
// Shared constants, types and helpers of the h-bridge control and fault logic.
// Notes on behaviour
// - drive needs enable, disables inactive, fault released
// - each output follows its own polarity input
// - equal polarity inputs brake both outputs alike
// - active disable: outputs off, fault line low
// - sleep or open enable: off, line released
// - open polarity reads high; open disable disables
// - undervoltage: outputs off, fault line low
// - undervoltage recovery restores outputs automatically
// - overcurrent or overtemperature latches outputs off
// - disable toggle or power cycle clears latch
// - current limit: fixed off time, then retry
// - limit folds back above 160 to 2.5A
// - above 175 degrees latch overtemperature shutdown
// - clear on disable edges; cool below hysteresis
// - off interval lasts twenty microseconds
// - overcurrent at blanking expiry latches shutdown
package hbcf_pkg;
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned T_OFF_NS = 20_000;
	localparam int unsigned T_BLANK_NS = 16_500;
	localparam int unsigned OFF_CYC_I = (T_OFF_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned BLANK_CYC_I = (T_BLANK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int TMR_W = 10;
	localparam logic [TMR_W-1:0] OFF_CYC = TMR_W'(OFF_CYC_I);
	localparam logic [TMR_W-1:0] BLANK_CYC = TMR_W'(BLANK_CYC_I);
	// temperatures in degrees c, currents in units of 0.1 a
	localparam logic [7:0] TJ_FOLD_C = 8'hA0;
	localparam logic [7:0] TJ_LIM_C = 8'hAF;
	localparam logic [7:0] TJ_SPAN_C = 8'h0F;
	localparam logic [7:0] I_FOLD_END = 8'h19;
	localparam logic [7:0] ILIM_NOM_RST = 8'h41;
	localparam logic [7:0] HYST_RST = 8'h0A;
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] OFS_ILIM = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_HYST = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 12'h00C;
	localparam logic [ADDR_W-1:0] OFS_STATE = 12'h010;
	localparam logic [ADDR_W-1:0] OFS_LIMIT = 12'h014;
	localparam int NUM_EV = 5;
	localparam int EV_UV = 0;
	localparam int EV_UV_REC = 1;
	localparam int EV_OC = 2;
	localparam int EV_OT = 3;
	localparam int EV_ILIM = 4;
	localparam logic [NUM_EV-1:0] IRQ_RST = 5'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic sleep_enable;
		logic disable_high_active;
		logic disable_low_active_n;
		logic polarity_a_in;
		logic polarity_b_in;
	} hbcf_pins_t;

	typedef enum logic [3:0] {
		CL_IDLE = 4'b0001,
		CL_BLANK = 4'b0010,
		CL_RUN = 4'b0100,
		CL_OFF = 4'b1000
	} hbcf_cl_state_t;

	typedef enum logic [2:0] {
		SEL_ILIM,
		SEL_HYST,
		SEL_IRQ_STATUS,
		SEL_IRQ_MASK,
		SEL_STATE,
		SEL_LIMIT,
		SEL_NONE
	} hbcf_sel_t;

	function automatic hbcf_sel_t reg_sel(input logic [ADDR_W-1:0] addr);
		unique case ({addr[ADDR_W-1:2], 2'h0})
			OFS_ILIM: return SEL_ILIM;
			OFS_HYST: return SEL_HYST;
			OFS_IRQ_STATUS: return SEL_IRQ_STATUS;
			OFS_IRQ_MASK: return SEL_IRQ_MASK;
			OFS_STATE: return SEL_STATE;
			OFS_LIMIT: return SEL_LIMIT;
			default: return SEL_NONE;
		endcase
	endfunction : reg_sel

	// linear fold-back of the limit between the two temperature points
	function automatic logic [7:0] fold_thr(input logic [7:0] nom, input logic [7:0] tj);
		logic [15:0] prod;
		prod = 16'h0000;
		if (tj <= TJ_FOLD_C)
			return nom;
		if (nom <= I_FOLD_END)
			return nom;
		if (tj >= TJ_LIM_C)
			return I_FOLD_END;
		prod = 16'(nom - I_FOLD_END) * 16'(tj - TJ_FOLD_C);
		return nom - 8'(prod / 16'(TJ_SPAN_C));
	endfunction : fold_thr
endpackage : hbcf_pkg

// *** tb/hbcf_load_model.sv ***
// Far side: fault line pull-up and a resistive motor load.
`timescale 1ns/1ps
module hbcf_load_model
	import hbcf_pkg::*;
(
	input wire logic fs_drv,
	input wire logic fs_oe,
	input wire logic out_a,
	input wire logic oe_a,
	input wire logic out_b,
	input wire logic oe_b,
	input wire logic [7:0] i_set,
	output logic fs_rd,
	output logic [7:0] i_load
);
	assign fs_rd = fs_oe ? fs_drv : 1'h1;
	// current flows only while both halves drive opposite levels
	assign i_load = (oe_a && oe_b && out_a != out_b) ? i_set : 8'h00;
endmodule : hbcf_load_model

// *** tb/hbcf_top_sva.sv ***
// Checker of bridge output and fault line relations.
`timescale 1ns/1ps
module hbcf_top_sva
	import hbcf_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire hbcf_pins_t pins,
	input wire hbcf_pins_t pins_open,
	input wire logic uv_detect,
	input wire logic fault_status_n_drv,
	input wire logic fault_status_n_oe,
	input wire logic bridge_out_a,
	input wire logic bridge_out_a_oe,
	input wire logic bridge_out_b,
	input wire logic bridge_out_b_oe
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	logic en_eff;
	logic dis_eff;
	assign en_eff = pins.sleep_enable && !pins_open.sleep_enable;
	assign dis_eff = pins.disable_high_active || pins_open.disable_high_active ||
		!pins.disable_low_active_n || pins_open.disable_low_active_n;
	// eight cycles cover synchroniser plus output flop
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer missing");
	chk_oe_pair: assert property (bridge_out_a_oe == bridge_out_b_oe)
		else $error("output enables differ");
	chk_z_level: assert property (!bridge_out_a_oe |-> !bridge_out_a && !bridge_out_b)
		else $error("level while high impedance");
	chk_drive_fs_high: assert property (bridge_out_a_oe |-> !fault_status_n_oe)
		else $error("drive with fault line low");
	chk_fs_open_drain: assert property (fault_status_n_oe |-> !fault_status_n_drv)
		else $error("fault line driven high");
	chk_sleep_off: assert property ((!en_eff)[*8] |-> !bridge_out_a_oe && !fault_status_n_oe)
		else $error("sleep not honoured");
	chk_dis_off: assert property ((en_eff && dis_eff)[*8] |->
		!bridge_out_a_oe && fault_status_n_oe)
		else $error("disable not honoured");
	chk_uv_off: assert property ((en_eff && uv_detect)[*8] |->
		!bridge_out_a_oe && fault_status_n_oe)
		else $error("undervoltage not honoured");
	chk_polarity_follow: assert property ($stable({pins, pins_open})[*8] ##0
		bridge_out_a_oe |->
		bridge_out_a == (pins.polarity_a_in || pins_open.polarity_a_in) &&
		bridge_out_b == (pins.polarity_b_in || pins_open.polarity_b_in))
		else $error("output does not follow polarity");
endmodule : hbcf_top_sva

// *** tb/test_hbcf_top.sv ***
// Self-checking testbench of the h-bridge control logic.
`timescale 1ns/1ps
module test_hbcf_top
	import hbcf_pkg::*;
;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, uv_detect;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [7:0] tj, i_set, i_load;
	hbcf_pins_t pins, pins_open;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic fault_status_n_rd, fault_status_n_drv, fault_status_n_oe;
	logic bridge_out_a, bridge_out_a_oe, bridge_out_b, bridge_out_b_oe;
	int n_errors = 0;
	int compares = 0;
	logic [4:0] obs;
	assign obs = {fault_status_n_rd, bridge_out_a_oe, bridge_out_a, bridge_out_b_oe, bridge_out_b};

	hbcf_top u_hbcf_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'h1), .s_axi_araddr, .s_axi_arprot(3'h0),
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready(1'h1), .pins, .pins_open, .uv_detect, .i_load, .tj, .fault_status_n_rd,
		.fault_status_n_drv, .fault_status_n_oe, .bridge_out_a, .bridge_out_a_oe,
		.bridge_out_b, .bridge_out_b_oe, .irq);
	hbcf_load_model u_hbcf_load_model (.fs_drv(fault_status_n_drv), .fs_oe(fault_status_n_oe),
		.out_a(bridge_out_a), .oe_a(bridge_out_a_oe), .out_b(bridge_out_b),
		.oe_b(bridge_out_b_oe), .i_set(i_set), .fs_rd(fault_status_n_rd), .i_load(i_load));

	initial begin
		aclk = 1'h0;
		forever #12.5 aclk = ~aclk;
	end

	task automatic give_verdict;
		$display("compares=%0d n_errors=%0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask : cyc

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid) break;
		end
		chk(32'(s_axi_bvalid), 32'h1);
		chk(32'(s_axi_bresp), 32'(er));
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic [1:0] er);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) break;
		end
		chk(32'(s_axi_rvalid), 32'h1);
		chk(s_axi_rdata, exp);
		chk(32'(s_axi_rresp), 32'(er));
	endtask : rd

	// pins then open-pin flags; twelve cycles cover sync, blanking entry and output flop
	task automatic pin_chk(input logic [4:0] v, input logic [4:0] o, input logic [4:0] e);
		@(posedge aclk);
		pins <= hbcf_pins_t'(v);
		pins_open <= hbcf_pins_t'(o);
		cyc(12);
		chk(32'(obs), 32'(e));
	endtask : pin_chk

	task automatic t_regs;
		rd(OFS_ILIM, 32'(ILIM_NOM_RST), RESP_OKAY);
		rd(OFS_HYST, 32'(HYST_RST), RESP_OKAY);
		rd(OFS_IRQ_MASK, 32'h0, RESP_OKAY);
		wr(OFS_HYST, 32'h14, RESP_OKAY);
		rd(OFS_HYST, 32'h14, RESP_OKAY);
		wr(OFS_HYST, 32'(HYST_RST), RESP_OKAY);
		// lane zero strobe off: accepted but nothing written
		s_axi_wstrb <= 4'h0;
		wr(OFS_HYST, 32'h33, RESP_OKAY);
		rd(OFS_HYST, 32'(HYST_RST), RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		wr(OFS_LIMIT, 32'h0, RESP_OKAY);
		rd(OFS_LIMIT, 32'(ILIM_NOM_RST), RESP_OKAY);
		wr(12'h020, 32'h1, RESP_SLVERR);
		rd(12'h020, 32'h0, RESP_SLVERR);
		$display("regs done");
	endtask : t_regs

	task automatic t_pins;
		int i;
		for (i = 0; i < 4; i++)
			pin_chk({3'h5, 2'(i)}, 5'h00, {2'h3, 1'(i >> 1), 1'h1, 1'(i)});
		pin_chk(5'h1E, 5'h00, 5'h00);
		pin_chk(5'h12, 5'h00, 5'h00);
		pin_chk(5'h0E, 5'h00, 5'h10);
		pin_chk(5'h16, 5'h08, 5'h00);
		pin_chk(5'h16, 5'h10, 5'h10);
		pin_chk(5'h14, 5'h01, 5'h1B);
		pin_chk(5'h16, 5'h00, 5'h1E);
		$display("pins done");
	endtask : t_pins

	task automatic t_uv;
		wr(OFS_IRQ_MASK, 32'h03, RESP_OKAY);
		@(posedge aclk) uv_detect <= 1'h1;
		cyc(12);
		chk(32'(obs), 32'h00);
		chk(32'(irq), 32'h1);
		wr(OFS_IRQ_STATUS, 32'h1F, RESP_OKAY);
		cyc(2);
		chk(32'(irq), 32'h0);
		@(posedge aclk) uv_detect <= 1'h0;
		cyc(12);
		chk(32'(obs), 32'h1E);
		rd(OFS_IRQ_STATUS, 32'h02, RESP_OKAY);
		chk(32'(irq), 32'h1);
		wr(OFS_IRQ_STATUS, 32'h1F, RESP_OKAY);
		wr(OFS_IRQ_MASK, 32'h00, RESP_OKAY);
		cyc(2);
		chk(32'(irq), 32'h0);
		$display("uv done");
	endtask : t_uv

	task automatic t_limit;
		int n;
		cyc(700);
		@(posedge aclk) i_set <= 8'h50;
		for (n = 0; n < 20 && bridge_out_a_oe; n++) @(posedge aclk);
		for (n = 0; n < 900 && !bridge_out_a_oe; n++) @(posedge aclk);
		chk(32'(n >= int'(OFF_CYC) - 2 && n <= int'(OFF_CYC) + 3), 32'h1);
		// load still over the limit when blanking runs out
		cyc(700);
		chk(32'(obs), 32'h00);
		rd(OFS_IRQ_STATUS, 32'h14, RESP_OKAY);
		@(posedge aclk) i_set <= 8'h00;
		pin_chk(5'h15, 5'h00, 5'h00);
		pin_chk(5'h1E, 5'h00, 5'h00);
		pin_chk(5'h16, 5'h00, 5'h1E);
		wr(OFS_IRQ_STATUS, 32'h1F, RESP_OKAY);
		$display("limit done");
	endtask : t_limit

	task automatic t_ot;
		@(posedge aclk) tj <= 8'hA8;
		cyc(6);
		rd(OFS_LIMIT, 32'h2C, RESP_OKAY);
		@(posedge aclk) tj <= 8'hB0;
		cyc(12);
		chk(32'(obs), 32'h00);
		rd(OFS_IRQ_STATUS, 32'h08, RESP_OKAY);
		@(posedge aclk) tj <= 8'hAA;
		pin_chk(5'h12, 5'h00, 5'h00);
		pin_chk(5'h16, 5'h00, 5'h10);
		rd(OFS_STATE, 32'h641, RESP_OKAY);
		@(posedge aclk) tj <= 8'h19;
		cyc(12);
		chk(32'(obs), 32'h1E);
		wr(OFS_IRQ_STATUS, 32'h1F, RESP_OKAY);
		$display("ot done");
	endtask : t_ot

	initial begin
		aresetn = 1'h0;
		s_axi_awvalid = 1'h0;
		s_axi_wvalid = 1'h0;
		s_axi_arvalid = 1'h0;
		s_axi_awaddr = 12'h000;
		s_axi_araddr = 12'h000;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		pins = hbcf_pins_t'(5'h16);
		pins_open = hbcf_pins_t'(5'h00);
		uv_detect = 1'h0;
		tj = 8'h19;
		i_set = 8'h00;
		cyc(4);
		aresetn <= 1'h1;
		cyc(12);
		t_regs();
		t_pins();
		t_uv();
		t_limit();
		t_ot();
		give_verdict();
	end

	initial begin
		cyc(20000);
		n_errors++;
		give_verdict();
	end
endmodule : test_hbcf_top

bind hbcf_top hbcf_top_sva u_hbcf_top_sva (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .pins, .pins_open, .uv_detect, .fault_status_n_drv, .fault_status_n_oe,
	.bridge_out_a, .bridge_out_a_oe, .bridge_out_b, .bridge_out_b_oe);
